// [hdl/ppcs_top.sv]
// Behaviour
// [RULE1] select out is inverse of control bit 3
// [RULE2] init out follows control bit 2 directly
// [RULE3] printer initialises on low init line
// [RULE4] line feed out is inverse of bit 1
// [RULE5] printer auto-feeds while line feed low
// [RULE6] strobe out is inverse of bit 0
// [RULE7] printer captures data on low strobe
// [RULE8] status bit 7 is inverted busy input
// [RULE9] printer holds busy high when not ready
// [RULE10] status bit 6 is acknowledge input level
// [RULE11] printer pulls acknowledge low when data taken
// [RULE12] second port interrupt gated by control bit 4
// [RULE13] mode strap latched while reset active
// [RULE14] status reads live, no latch, no clear
// [RULE15] status bit 5 is paper end level
// [RULE16] status bits 4, 3 are online, fault
`timescale 1ns/10ps
`default_nettype none
module ppcs_top
    import ppcs_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [APB_AW-1:0] paddr,
    input wire logic [APB_DW-1:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [APB_DW-1:0] prdata,
    output logic pready,
    output logic pslverr,
    // printer control outputs
    output logic printer_select_out_n,
    output logic printer_init_out_n,
    output logic auto_line_feed_out_n,
    output logic data_strobe_out_n,
    // printer status inputs
    input wire logic printer_busy_in,
    input wire logic printer_ack_in_n,
    input wire logic paper_out_in,
    input wire logic printer_online_in,
    input wire logic printer_fault_in_n,
    // mode strap
    input wire logic enhanced_mode_strap,
    output logic enhanced_mode,
    // interrupts
    output logic port_irq_second,
    output logic irq
);

    // word match on the index field; low address bits are ignored
    function automatic logic ppcs_hit(input logic [APB_AW-1:0] a, input logic [APB_AW-1:0] ofs);
        return a[APB_AW-1:ADDR_LSB] == ofs[APB_AW-1:ADDR_LSB];
    endfunction

    // level change detectors shared by all event sources
    function automatic logic ppcs_fell(input logic was, input logic now);
        return was & ~now;
    endfunction

    function automatic logic ppcs_rose(input logic was, input logic now);
        return ~was & now;
    endfunction

    // bus phase qualifiers
    logic setup_ph;
    logic access_ph;
    logic wr_lane0;

    // register state
    ppcs_ctrl_t ctrl_r;
    logic [APB_DW-1:0] rd_data_r;
    logic [APB_DW-1:0] rd_data_nxt;
    logic err_r;
    logic err_nxt;
    logic rd_irq_stat_r;

    // input path
    ppcs_in_t pins_raw;
    ppcs_in_t pins_s;
    ppcs_in_t pins_prev_r;
    ppcs_ev_t ev_set;
    ppcs_ev_t ev_clr;
    ppcs_ev_t ev_sticky;
    ppcs_ev_t ev_mask;
    logic mask_we;

    // strap capture
    logic strap_s1_r;
    logic strap_s2_r;
    logic strap_s3_r;
    logic mode_r;

    // second port interrupt
    logic port_irq_second_r;

    // setup cycle loads read data, access cycle commits
    assign setup_ph = psel & ~penable;
    assign access_ph = psel & penable;
    assign wr_lane0 = access_ph & pwrite & pstrb[0];

    // zero wait states: every access completes in its first access cycle
    assign pready = access_ph;
    assign pslverr = access_ph & err_r;
    assign prdata = rd_data_r;

    // all status pins enter through one synchroniser
    assign pins_raw[IN_BUSY] = printer_busy_in;
    assign pins_raw[IN_ACK] = printer_ack_in_n;
    assign pins_raw[IN_PAPER] = paper_out_in;
    assign pins_raw[IN_ONLINE] = printer_online_in;
    assign pins_raw[IN_FAULT] = printer_fault_in_n;

    ppcs_sync #(
        .W(IN_W),
        .RST_VAL(IN_RST)
    ) u_sync (
        .clk(clk),
        .rst(rst),
        .din(pins_raw),
        .dout(pins_s)
    );

    // previous filtered levels for edge detection
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pins_prev_r <= IN_RST;
        end else begin
            pins_prev_r <= pins_s;
        end
    end

    // events: ack and fault falling, busy falling, paper rising, online falling
    always_comb begin
        ev_set = '0;
        ev_set[EV_ACK] = ppcs_fell(pins_prev_r[IN_ACK], pins_s[IN_ACK]);
        ev_set[EV_READY] = ppcs_fell(pins_prev_r[IN_BUSY], pins_s[IN_BUSY]);
        ev_set[EV_PAPER] = ppcs_rose(pins_prev_r[IN_PAPER], pins_s[IN_PAPER]);
        ev_set[EV_OFFLINE] = ppcs_fell(pins_prev_r[IN_ONLINE], pins_s[IN_ONLINE]);
        ev_set[EV_FAULT] = ppcs_fell(pins_prev_r[IN_FAULT], pins_s[IN_FAULT]);
    end

    // read of the event register clears exactly the bits it returned,
    // so an event set after the data was captured survives the read
    assign ev_clr = (access_ph & ~pwrite & rd_irq_stat_r) ? rd_data_r[EV_W-1:0] : '0;
    assign mask_we = wr_lane0 & ppcs_hit(paddr, OFS_IRQ_MASK);

    ppcs_irq #(
        .N(EV_W),
        .MASK_RST_VAL(MASK_RST)
    ) u_irq (
        .clk(clk),
        .rst(rst),
        .ev_set(ev_set),
        .rd_clr(ev_clr),
        .mask_we(mask_we),
        .mask_wdata(pwdata[EV_W-1:0]),
        .sticky(ev_sticky),
        .mask(ev_mask),
        .irq(irq)
    );

    // control register; only byte lane 0 holds bits
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ctrl_r <= CTRL_RST;
        end else if (wr_lane0 && ppcs_hit(paddr, OFS_CTRL)) begin
            ctrl_r <= pwdata[CTRL_W-1:0];
        end
    end

    // pin drivers: single inverters behind the control flops, except init which follows its flop directly
    assign printer_select_out_n = ~ctrl_r[CTRL_SELECT]; // see [RULE1]
    assign printer_init_out_n = ctrl_r[CTRL_INIT]; // see [RULE2]
    assign auto_line_feed_out_n = ~ctrl_r[CTRL_AUTOFD]; // see [RULE4]
    // strobe width is set by software timing between two writes
    assign data_strobe_out_n = ~ctrl_r[CTRL_STROBE]; // see [RULE6]

    // read mux, evaluated in the setup cycle
    always_comb begin
        rd_data_nxt = '0;
        err_nxt = 1'b0;
        if (ppcs_hit(paddr, OFS_CTRL)) begin
            rd_data_nxt[CTRL_W-1:0] = ctrl_r;
        end else if (ppcs_hit(paddr, OFS_STATUS)) begin
            // live filtered levels, no side effect on read
            rd_data_nxt[ST_NOT_BUSY] = ~pins_s[IN_BUSY]; // see [RULE8] [RULE14]
            rd_data_nxt[ST_ACK] = pins_s[IN_ACK]; // see [RULE10]
            rd_data_nxt[ST_PAPER] = pins_s[IN_PAPER]; // see [RULE15]
            rd_data_nxt[ST_ONLINE] = pins_s[IN_ONLINE]; // see [RULE16]
            rd_data_nxt[ST_FAULT] = pins_s[IN_FAULT]; // see [RULE16]
        end else if (ppcs_hit(paddr, OFS_IRQ_STAT)) begin
            rd_data_nxt[EV_W-1:0] = ev_sticky;
        end else if (ppcs_hit(paddr, OFS_IRQ_MASK)) begin
            rd_data_nxt[EV_W-1:0] = ev_mask;
        end else if (ppcs_hit(paddr, OFS_MODE)) begin
            rd_data_nxt[MODE_ENHANCED] = mode_r;
        end else begin
            err_nxt = 1'b1;
        end
    end

    // capture read data and decode in the setup cycle; held through access
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rd_data_r <= '0;
            err_r <= 1'b0;
            rd_irq_stat_r <= 1'b0;
        end else if (setup_ph) begin
            rd_data_r <= pwrite ? '0 : rd_data_nxt;
            err_r <= err_nxt;
            rd_irq_stat_r <= ~pwrite & ppcs_hit(paddr, OFS_IRQ_STAT);
        end
    end

    // strap: three stages without reset so they keep sampling while reset is held;
    // only the second stage reads the first
    always_ff @(posedge clk) begin
        strap_s1_r <= enhanced_mode_strap;
        strap_s2_r <= strap_s1_r;
        strap_s3_r <= strap_s2_r;
    end

    // latch follows the strap only while reset is high and the late stages agree,
    // so reset must last at least four edges with the clock running
    always_ff @(posedge clk) begin
        if (rst && (strap_s2_r == strap_s3_r)) begin
            mode_r <= strap_s3_r; // see [RULE13]
        end
    end

    assign enhanced_mode = mode_r;

    // second port interrupt follows a low acknowledge, only when enabled
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            port_irq_second_r <= 1'b0;
        end else begin
            port_irq_second_r <= ctrl_r[CTRL_IRQ_EN] & ~pins_s[IN_ACK]; // see [RULE12]
        end
    end

    assign port_irq_second = port_irq_second_r;

endmodule // ppcs_top
`default_nettype wire

// [inc/ppcs_pkg.sv]
`default_nettype none
package ppcs_pkg;

    // apb address width and data width
    localparam int unsigned APB_AW = 8;
    localparam int unsigned APB_DW = 32;

    // register byte offsets, one aligned word each
    localparam logic [APB_AW-1:0] OFS_CTRL = 8'h00;
    localparam logic [APB_AW-1:0] OFS_STATUS = 8'h04;
    localparam logic [APB_AW-1:0] OFS_IRQ_STAT = 8'h08;
    localparam logic [APB_AW-1:0] OFS_IRQ_MASK = 8'h0C;
    localparam logic [APB_AW-1:0] OFS_MODE = 8'h10;

    // word index field of the address
    localparam int unsigned ADDR_LSB = 2;

    // printer control register fields
    localparam int unsigned CTRL_STROBE = 0;
    localparam int unsigned CTRL_AUTOFD = 1;
    localparam int unsigned CTRL_INIT = 2;
    localparam int unsigned CTRL_SELECT = 3;
    localparam int unsigned CTRL_IRQ_EN = 4;
    localparam int unsigned CTRL_W = 5;
    localparam logic [CTRL_W-1:0] CTRL_RST = 5'h04;

    // printer status register fields
    localparam int unsigned ST_FAULT = 3;
    localparam int unsigned ST_ONLINE = 4;
    localparam int unsigned ST_PAPER = 5;
    localparam int unsigned ST_ACK = 6;
    localparam int unsigned ST_NOT_BUSY = 7;

    // synchronised input vector layout and idle levels
    localparam int unsigned IN_BUSY = 0;
    localparam int unsigned IN_ACK = 1;
    localparam int unsigned IN_PAPER = 2;
    localparam int unsigned IN_ONLINE = 3;
    localparam int unsigned IN_FAULT = 4;
    localparam int unsigned IN_W = 5;
    localparam logic [IN_W-1:0] IN_RST = 5'h12;

    // interrupt event bits, same layout in status and mask
    localparam int unsigned EV_ACK = 0;
    localparam int unsigned EV_READY = 1;
    localparam int unsigned EV_PAPER = 2;
    localparam int unsigned EV_OFFLINE = 3;
    localparam int unsigned EV_FAULT = 4;
    localparam int unsigned EV_W = 5;
    localparam logic [EV_W-1:0] MASK_RST = 5'h00;

    // mode register field
    localparam int unsigned MODE_ENHANCED = 0;

    typedef logic [IN_W-1:0] ppcs_in_t;
    typedef logic [EV_W-1:0] ppcs_ev_t;
    typedef logic [CTRL_W-1:0] ppcs_ctrl_t;

endpackage
`default_nettype wire

// [hdl/ppcs_sync.sv]
`timescale 1ns/10ps
`default_nettype none
module ppcs_sync #(
    parameter int unsigned W = 1,
    parameter logic [W-1:0] RST_VAL = '0
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // asynchronous levels in, filtered levels out
    input wire logic [W-1:0] din,
    output logic [W-1:0] dout
);

    logic [W-1:0] s1_r;
    logic [W-1:0] s2_r;
    logic [W-1:0] s3_r;
    logic [W-1:0] dout_r;

    // three stages; s1 feeds only s2 so metastability never reaches logic
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            s1_r <= RST_VAL;
            s2_r <= RST_VAL;
            s3_r <= RST_VAL;
        end else begin
            s1_r <= din;
            s2_r <= s1_r;
            s3_r <= s2_r;
        end
    end

    // a bit changes only once stages two and three agree, so a one-cycle glitch is dropped
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            dout_r <= RST_VAL;
        end else begin
            dout_r <= ((s2_r ~^ s3_r) & s3_r) | ((s2_r ^ s3_r) & dout_r);
        end
    end

    assign dout = dout_r;

endmodule // ppcs_sync
`default_nettype wire

// [hdl/ppcs_irq.sv]
`timescale 1ns/10ps
`default_nettype none
module ppcs_irq #(
    parameter int unsigned N = 5,
    parameter logic [N-1:0] MASK_RST_VAL = '0
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // event pulses and read-clear vector
    input wire logic [N-1:0] ev_set,
    input wire logic [N-1:0] rd_clr,
    // mask write
    input wire logic mask_we,
    input wire logic [N-1:0] mask_wdata,
    // state and interrupt
    output logic [N-1:0] sticky,
    output logic [N-1:0] mask,
    output logic irq
);

    logic [N-1:0] sticky_r;
    logic [N-1:0] mask_r;

    // set wins over clear so an event landing on the clearing read is kept
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            sticky_r <= '0;
        end else begin
            sticky_r <= (sticky_r & ~rd_clr) | ev_set;
        end
    end

    // mask register
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            mask_r <= MASK_RST_VAL;
        end else if (mask_we) begin
            mask_r <= mask_wdata;
        end
    end

    // level interrupt, from flops only
    assign irq = |(sticky_r & mask_r);
    assign sticky = sticky_r;
    assign mask = mask_r;

endmodule // ppcs_irq
`default_nettype wire

// [dv/ppcs_checker.sv]
`timescale 1ns/10ps
`default_nettype none
module ppcs_checker
    import ppcs_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // apb
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic [APB_AW-1:0] paddr,
    input wire logic [APB_DW-1:0] pwdata,
    input wire logic [APB_DW-1:0] prdata,
    input wire logic [3:0] pstrb,
    // printer pins
    input wire logic printer_select_out_n,
    input wire logic printer_init_out_n,
    input wire logic auto_line_feed_out_n,
    input wire logic data_strobe_out_n,
    input wire logic printer_busy_in,
    input wire logic printer_ack_in_n,
    input wire logic paper_out_in,
    input wire logic printer_online_in,
    input wire logic printer_fault_in_n,
    // mode and interrupts
    input wire logic enhanced_mode_strap,
    input wire logic enhanced_mode,
    input wire logic port_irq_second,
    input wire logic irq
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    // mirror of the port interrupt enable, taken from committed control writes
    logic irq_en_q;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            irq_en_q <= CTRL_RST[CTRL_IRQ_EN];
        end else if (psel && penable && pready && pwrite && pstrb[0] && paddr == OFS_CTRL) begin
            irq_en_q <= pwdata[CTRL_IRQ_EN];
        end
    end
    // committed control write
    sequence s_wr;
        psel && penable && pready && pwrite && paddr == OFS_CTRL && pstrb[0];
    endsequence
    // setup of a status read
    sequence s_rd;
        psel && !penable && !pwrite && paddr == OFS_STATUS;
    endsequence
    AST_SELECT: assert property (s_wr |=> printer_select_out_n == !$past(pwdata[3]))
        else $error("select pin wrong");
    AST_INIT: assert property (s_wr |=> printer_init_out_n == $past(pwdata[2]))
        else $error("init pin wrong");
    AST_FEED: assert property (s_wr |=> auto_line_feed_out_n == !$past(pwdata[1]))
        else $error("line feed pin wrong");
    AST_STROBE: assert property (s_wr |=> data_strobe_out_n == !$past(pwdata[0]))
        else $error("strobe pin wrong");
    // pins must be quiet long enough to pass the input filter
    AST_BUSY: assert property ($stable(printer_busy_in)[*6] ##0 s_rd |=> prdata[7] == !$past(printer_busy_in))
        else $error("busy bit wrong");
    AST_ACK: assert property ($stable(printer_ack_in_n)[*6] ##0 s_rd |=> prdata[6] == $past(printer_ack_in_n))
        else $error("ack bit wrong");
    // held off for as long as the enable stays clear, whatever the acknowledge line does
    AST_PIRQ: assert property (!irq_en_q |=> !port_irq_second)
        else $error("port irq not gated");
    AST_MODE: assert property ($fell(rst) |-> enhanced_mode == $past(enhanced_mode_strap))
        else $error("strap not latched");
endmodule // ppcs_checker
`default_nettype wire

// [dv/ppcs_printer.sv]
`timescale 1ns/10ps
`default_nettype none
module ppcs_printer #(
    parameter int BUSY_CYC = 12,
    parameter int ACK_CYC = 6
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // control lines from the port
    input wire logic data_strobe_out_n,
    input wire logic printer_init_out_n,
    input wire logic auto_line_feed_out_n,
    // handshake lines back to the port
    output logic printer_busy_in,
    output logic printer_ack_in_n,
    // lines advanced by the automatic feed
    output logic [7:0] line_feeds
);
    int cnt;
    logic stb_q;
    // one print job per strobe fall; strobes while busy are lost, as on a real printer
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cnt <= 0;
            stb_q <= 1'b1;
            line_feeds <= 8'h00;
        end else if (!printer_init_out_n) begin
            cnt <= 0;
        end else begin
            stb_q <= data_strobe_out_n;
            if (stb_q && !data_strobe_out_n && cnt == 0) begin
                cnt <= BUSY_CYC + ACK_CYC;
            end else if (cnt != 0) begin
                cnt <= cnt - 1;
                // the line ends with the job; it is fed only while the feed line is low
                if (cnt == 1 && !auto_line_feed_out_n) begin
                    line_feeds <= line_feeds + 8'h01;
                end
            end
        end
    end
    // ack pulse sits at the tail of the busy time
    assign printer_busy_in = cnt != 0;
    assign printer_ack_in_n = !(cnt != 0 && cnt <= ACK_CYC);
endmodule // ppcs_printer
`default_nettype wire

// [dv/test_printer_port_control_status_pins.sv]
`timescale 1ns/10ps
`default_nettype none
module test_printer_port_control_status_pins;
    import ppcs_pkg::*;
    logic clk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [APB_AW-1:0] paddr = '0;
    logic [APB_DW-1:0] pwdata = '0, prdata, q;
    logic [3:0] pstrb = 4'hF;
    logic pready, pslverr, err, printer_select_out_n, printer_init_out_n, auto_line_feed_out_n;
    logic data_strobe_out_n, printer_busy_in, printer_ack_in_n, enhanced_mode, port_irq_second, irq;
    logic [7:0] line_feeds;
    logic paper_out_in = 1'b0, printer_online_in = 1'b1, printer_fault_in_n = 1'b1, enhanced_mode_strap = 1'b1;
    int failures = 0, n_tests = 0;
    ppcs_top dut (.*);
    ppcs_printer pm (.*);
    always #20 clk = ~clk;
    task automatic end_of_test;
        if (failures == 0 && n_tests > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    task automatic cmp(input logic [31:0] g, input logic [31:0] e);
        n_tests++;
        if (g !== e) begin
            failures++;
            $display("BAD %0t got %h exp %h", $time, g, e);
        end
    endtask
    // one apb transfer; request held until pready is seen high
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1) @(posedge clk);
        q = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // reset values and the latched strap
    task automatic t_reset(input logic s);
        apb(1'b0, OFS_CTRL, 32'h0);
        cmp(q, 32'(CTRL_RST));
        cmp(32'({printer_select_out_n, printer_init_out_n, auto_line_feed_out_n, data_strobe_out_n}), 32'hF);
        cmp(32'(enhanced_mode), 32'(s));
        apb(1'b0, OFS_IRQ_MASK, 32'h0);
        cmp(q, 32'h0);
        apb(1'b0, OFS_MODE, 32'h0);
        cmp(q, 32'(s));
    endtask
    // every level of the three static status pins, each read twice
    task automatic t_status;
        for (int i = 0; i < 8; i++) begin
            {paper_out_in, printer_online_in, printer_fault_in_n} <= 3'(i);
            repeat (6) @(posedge clk);
            repeat (2) begin
                apb(1'b0, OFS_STATUS, 32'h0);
                cmp(q, 32'({2'b11, 3'(i), 3'h0}));
            end
        end
    endtask
    // one print job with auto feed: handshake bits, port irq gate, sticky events and mask
    task automatic t_print(input logic en, input logic [4:0] m);
        int k;
        logic [7:0] lf;
        lf = line_feeds;
        apb(1'b1, OFS_IRQ_MASK, 32'(m));
        apb(1'b0, OFS_IRQ_STAT, 32'h0);
        apb(1'b1, OFS_CTRL, 32'({en, 4'h7}));
        apb(1'b1, OFS_CTRL, 32'({en, 4'h6}));
        k = 0;
        do begin
            apb(1'b0, OFS_STATUS, 32'h0);
            k++;
        end while (q[ST_ACK] !== 1'b0 && k < 40);
        cmp(32'(q[7:6]), 32'h0);
        cmp(32'(port_irq_second), 32'(en));
        do begin
            apb(1'b0, OFS_STATUS, 32'h0);
            k++;
        end while (q[ST_NOT_BUSY] !== 1'b1 && k < 80);
        cmp(32'(irq), 32'(|(m & 5'h03)));
        apb(1'b0, OFS_IRQ_STAT, 32'h0);
        cmp(q, 32'h3);
        cmp(32'(line_feeds), 32'(lf) + 32'h1);
        @(posedge clk);
        cmp(32'(irq), 32'h0);
    endtask
    // all control values, then a write with its byte lane off
    task automatic t_ctrl;
        for (int i = 0; i < 32; i++) begin
            apb(1'b1, OFS_CTRL, 32'(i));
            @(posedge clk);
            cmp(32'(printer_select_out_n), 32'(!i[3]));
            cmp(32'(printer_init_out_n), 32'(i[2]));
            cmp(32'(auto_line_feed_out_n), 32'(!i[1]));
            cmp(32'(data_strobe_out_n), 32'(!i[0]));
        end
        pstrb <= 4'h0;
        apb(1'b1, OFS_CTRL, 32'h4);
        pstrb <= 4'hF;
        apb(1'b0, OFS_CTRL, 32'h0);
        cmp(q, 32'h1F);
        apb(1'b1, OFS_CTRL, 32'h4);
    endtask
    // unmapped address answers with an error and changes nothing
    task automatic t_unmapped;
        apb(1'b1, 8'h14, 32'h1F);
        cmp(32'(err), 32'h1);
        apb(1'b0, 8'h14, 32'h0);
        cmp(q, 32'h0);
        apb(1'b0, OFS_CTRL, 32'h0);
        cmp(q, 32'h4);
    endtask
    // reset in mid-run with the other strap level
    task automatic t_rerun;
        enhanced_mode_strap <= 1'b0;
        rst <= 1'b1;
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        t_reset(1'b0);
    endtask
    initial begin
        #200000;
        failures++;
        end_of_test;
    end
    initial begin
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        t_reset(1'b1);
        t_status;
        t_print(1'b1, 5'h01);
        t_print(1'b0, 5'h00);
        t_ctrl;
        t_unmapped;
        t_rerun;
        end_of_test;
    end
endmodule // test_printer_port_control_status_pins
bind ppcs_top ppcs_checker chk (.*);
`default_nettype wire
